// >>> verilog/ufc_pkg.sv
// constants for the uart flow-control and special-character block
package ufc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] UFC_ADDR_FLOW_LEVELS  = 8'h0f;
    localparam logic [7:0] UFC_ADDR_RX_COUNT     = 8'h12;
    localparam logic [7:0] UFC_ADDR_FLOW_CONFIG  = 8'h13;
    localparam logic [7:0] UFC_ADDR_RESUME_FIRST = 8'h14;
    localparam logic [7:0] UFC_ADDR_RESUME_SECND = 8'h15;
    localparam logic [7:0] UFC_ADDR_HALT_FIRST   = 8'h16;
    localparam logic [7:0] UFC_ADDR_HALT_SECOND  = 8'h17;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] UFC_RST_REG = 8'h00;
    localparam logic [7:0] UFC_RST_RD  = 8'h00;

    // ------------------------------------------------------------
    // flow_control_config fields
    // ------------------------------------------------------------
    localparam int UFC_TX_SEL_HI   = 7;
    localparam int UFC_TX_SEL_LO   = 6;
    localparam int UFC_RX_SEL_HI   = 5;
    localparam int UFC_RX_SEL_LO   = 4;
    localparam int UFC_SW_EN_BIT   = 3;
    localparam int UFC_GPIO_AD_BIT = 2;
    localparam int UFC_ACTS_BIT    = 1;
    localparam int UFC_ARTS_BIT    = 0;

    // pair selection codes
    localparam logic [1:0] UFC_SEL_NONE   = 2'h0;
    localparam logic [1:0] UFC_SEL_SECOND = 2'h1;
    localparam logic [1:0] UFC_SEL_FIRST  = 2'h2;
    localparam logic [1:0] UFC_SEL_DOUBLE = 2'h3;

    // match vector layout: [0] resume1 [1] resume2 [2] halt1 [3] halt2
    localparam logic [3:0] UFC_MASK_FIRST  = 4'h5;
    localparam logic [3:0] UFC_MASK_SECOND = 4'ha;
    localparam logic [3:0] UFC_MASK_HALT   = 4'hc;
    localparam logic [3:0] UFC_MASK_RESUME = 4'h3;

    // threshold granularity shift (level = 8 x field)
    localparam int UFC_LEVEL_SHIFT = 3;

    // threshold level in words from a four-bit field
    function automatic logic [7:0] ufc_level(input logic [3:0] field);
        return {1'b0, field, 3'h0};
    endfunction

endpackage

// >>> verilog/ufc_char_match.sv
// compares one received character with the four programmed characters
`timescale 1ns/100ps
module ufc_char_match
    import ufc_pkg::*;
(
    input  wire logic [7:0] rx_char,
    input  wire logic [7:0] resume_char_first,
    input  wire logic [7:0] resume_char_second,
    input  wire logic [7:0] halt_char_first,
    input  wire logic [7:0] halt_char_second,
    input  wire logic       gpio_address_enable,
    input  wire logic [3:0] gpio_level,
    output logic      [3:0] match
);

    logic [7:0] halt_second_eff;

    // ------------------------------------------------------------
    // compare
    // ------------------------------------------------------------
    always_comb begin
        halt_second_eff = halt_char_second;
        if (gpio_address_enable) begin
            halt_second_eff = {halt_char_second[7:4], gpio_level}; // R8 R9
        end
        match[0] = (rx_char == resume_char_first);
        match[1] = (rx_char == resume_char_second);
        match[2] = (rx_char == halt_char_first);
        match[3] = (rx_char == halt_second_eff);
    end

endmodule // ufc_char_match

// >>> verilog/ufc_flow_sender.sv
// hands one or two flow-control characters to the transmitter
`timescale 1ns/100ps
module ufc_flow_sender
    import ufc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic       send_halt,
    input  wire logic       send_resume,
    input  wire logic [1:0] pair_sel,
    input  wire logic [7:0] resume_char_first,
    input  wire logic [7:0] resume_char_second,
    input  wire logic [7:0] halt_char_first,
    input  wire logic [7:0] halt_char_second,
    input  wire logic       tx_flow_ack,
    output logic            flow_req_q,
    output logic      [7:0] flow_char_q,
    output logic            busy_q
);

    typedef enum logic [1:0] {
        UFC_SND_IDLE   = 2'b00,
        UFC_SND_FIRST  = 2'b01,
        UFC_SND_SECOND = 2'b10
    } ufc_snd_state_t;

    typedef struct packed {
        ufc_snd_state_t state;
        logic           halt;
        logic           dbl;
        logic           req;
        logic [7:0]     chr;
    } ufc_snd_t;

    ufc_snd_t q;
    ufc_snd_t d;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        case (q.state)
            UFC_SND_IDLE: begin
                if (send_halt || send_resume) begin
                    d.halt  = send_halt;
                    d.dbl   = (pair_sel == UFC_SEL_DOUBLE);
                    d.req   = 1'b1;
                    d.state = UFC_SND_FIRST;
                    // R2 R14 R17
                    if (pair_sel == UFC_SEL_SECOND) begin
                        d.chr = send_halt ? halt_char_second : resume_char_second;
                    end else begin
                        d.chr = send_halt ? halt_char_first : resume_char_first;
                    end
                end
            end
            UFC_SND_FIRST: begin
                if (tx_flow_ack) begin
                    if (q.dbl) begin
                        d.chr   = q.halt ? halt_char_second : resume_char_second; // R14 R17
                        d.state = UFC_SND_SECOND;
                    end else begin
                        d.req   = 1'b0;
                        d.state = UFC_SND_IDLE;
                    end
                end
            end
            UFC_SND_SECOND: begin
                if (tx_flow_ack) begin
                    d.req   = 1'b0;
                    d.state = UFC_SND_IDLE;
                end
            end
            default: begin
                d.req   = 1'b0;
                d.state = UFC_SND_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign flow_req_q  = q.req;
    assign flow_char_q = q.chr;
    assign busy_q      = (q.state != UFC_SND_IDLE);

endmodule // ufc_flow_sender

// >>> verilog/ufc_flow_ctrl.sv
// flow-control and special-character top for one uart channel
// Function
// R1: receive fill count register is read-only, eight-bit word count of the receive fifo
// R2: transmit select bits pick first pair, second pair, all four, or none to send
// R3: receive select bits pick which received characters are compared and flagged
// R4: with receive software flow active, matching resume/halt characters are not stored
// R5: software flow enable bit turns on automatic software flow control
// R6: special detect without software flow enable flags characters, no transmit gating
// R7: special detect plus software flow: first pair flows, second pair is special
// R8: gpio address bit makes halt-second low nibble come from the gpio inputs
// R9: stored halt-second low nibble is ignored then but still reads back as stored
// R10: auto clear-to-send pauses and resumes the transmitter by the cts level
// R11: every cts level change raises the cts change flag event
// R12: software disables the transmitter before enabling auto clear-to-send
// R13: auto request-to-send drives rts from fill count at halt and resume levels
// R14: single mode uses each resume char; double mode sends first low, second high
// R15: special detect without flow control makes resume registers special characters; the code also flags halt characters, chosen by the receive select bits
// R16: halt and resume levels are eight times the four-bit field, 0 to 120
// R17: double mode halt sequence is first halt low byte, second halt high byte
// R18: each received character matching a special character raises an event and is stored
`timescale 1ns/100ps
module ufc_flow_ctrl
    import ufc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_q,
    input  wire logic       special_detect_enable,
    input  wire logic [7:0] rx_fifo_count,
    input  wire logic       rx_char_valid,
    input  wire logic [7:0] rx_char,
    output logic            rx_fifo_wr_q,
    output logic      [7:0] rx_fifo_data_q,
    output logic            special_char_event_q,
    output logic      [3:0] special_match_q,
    input  wire logic       cts_n,
    input  wire logic [3:0] gpio_in,
    output logic            cts_change_flag_q,
    output logic            rts_n_q,
    output logic            tx_data_allow_q,
    output logic            flow_req_q,
    output logic      [7:0] flow_char_q,
    input  wire logic       tx_flow_ack
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] levels;
        logic [7:0] cfg;
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] halt1;
        logic [7:0] halt2;
        logic [7:0] rdata;
        logic       cts_s1;
        logic       cts_s2;
        logic       cts_prev;
        logic [3:0] gpio_s1;
        logic [3:0] gpio_s2;
        logic       cts_evt;
        logic       rts_n;
        logic       tx_allow;
        logic       rx_halted;
        logic       halt_sent;
        logic       send_halt;
        logic       send_resume;
        logic       fifo_wr;
        logic [7:0] fifo_data;
        logic       spec_evt;
        logic [3:0] spec_match;
    } ufc_top_t;

    ufc_top_t q;
    ufc_top_t d;

    logic [3:0] match;
    logic       sender_busy;
    logic [1:0] tx_sel;
    logic [1:0] rx_sel;
    logic       sw_en;
    logic       auto_cts;
    logic       auto_rts;
    logic [3:0] sel_mask;
    logic [3:0] flow_mask;
    logic [3:0] spec_mask;
    logic [3:0] flow_hit;
    logic [7:0] halt_level;
    logic [7:0] resume_level;
    logic       above_halt;
    logic       below_resume;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    ufc_char_match u_match (
        .rx_char             (rx_char),
        .resume_char_first   (q.resume1),
        .resume_char_second  (q.resume2),
        .halt_char_first     (q.halt1),
        .halt_char_second    (q.halt2),
        .gpio_address_enable (q.cfg[UFC_GPIO_AD_BIT]),
        .gpio_level          (q.gpio_s2),
        .match               (match)
    );

    ufc_flow_sender u_sender (
        .ref_clk            (ref_clk),
        .reset_n            (reset_n),
        .ce                 (ce),
        .send_halt          (q.send_halt),
        .send_resume        (q.send_resume),
        .pair_sel           (tx_sel),
        .resume_char_first  (q.resume1),
        .resume_char_second (q.resume2),
        .halt_char_first    (q.halt1),
        .halt_char_second   (q.halt2),
        .tx_flow_ack        (tx_flow_ack),
        .flow_req_q         (flow_req_q),
        .flow_char_q        (flow_char_q),
        .busy_q             (sender_busy)
    );

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    always_comb begin
        sw_en    = q.cfg[UFC_SW_EN_BIT]; // R5
        auto_cts = q.cfg[UFC_ACTS_BIT];
        auto_rts = q.cfg[UFC_ARTS_BIT];
        rx_sel   = q.cfg[UFC_RX_SEL_HI:UFC_RX_SEL_LO]; // R3
        tx_sel   = UFC_SEL_NONE;
        if (sw_en) begin
            tx_sel = q.cfg[UFC_TX_SEL_HI:UFC_TX_SEL_LO]; // R2
            if (special_detect_enable) begin
                tx_sel = UFC_SEL_FIRST; // R7
            end
        end
        sel_mask = (rx_sel[1] ? UFC_MASK_FIRST : 4'h0)
                 | (rx_sel[0] ? UFC_MASK_SECOND : 4'h0);
        flow_mask = 4'h0;
        spec_mask = 4'h0;
        if (sw_en) begin
            flow_mask = special_detect_enable ? (sel_mask & UFC_MASK_FIRST) : sel_mask; // R7
        end
        if (special_detect_enable) begin
            spec_mask = sw_en ? UFC_MASK_SECOND : sel_mask; // R6 R7 R15
        end
        flow_hit     = match & flow_mask;
        halt_level   = ufc_level(q.levels[3:0]); // R16
        resume_level = ufc_level(q.levels[7:4]); // R16
        above_halt   = (rx_fifo_count >= halt_level);
        below_resume = (rx_fifo_count <= resume_level);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;

        // pin synchronisers
        d.cts_s1  = cts_n;
        d.cts_s2  = q.cts_s1;
        d.gpio_s1 = gpio_in;
        d.gpio_s2 = q.gpio_s1;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                UFC_ADDR_FLOW_LEVELS:  d.levels  = reg_wdata;
                UFC_ADDR_FLOW_CONFIG:  d.cfg     = reg_wdata;
                UFC_ADDR_RESUME_FIRST: d.resume1 = reg_wdata;
                UFC_ADDR_RESUME_SECND: d.resume2 = reg_wdata;
                UFC_ADDR_HALT_FIRST:   d.halt1   = reg_wdata;
                UFC_ADDR_HALT_SECOND:  d.halt2   = reg_wdata;
                default: begin
                end
            endcase
        end

        // register reads, one cycle latency
        if (reg_rd) begin
            case (reg_addr)
                UFC_ADDR_FLOW_LEVELS:  d.rdata = q.levels;
                UFC_ADDR_RX_COUNT:     d.rdata = rx_fifo_count; // R1
                UFC_ADDR_FLOW_CONFIG:  d.rdata = q.cfg;
                UFC_ADDR_RESUME_FIRST: d.rdata = q.resume1;
                UFC_ADDR_RESUME_SECND: d.rdata = q.resume2;
                UFC_ADDR_HALT_FIRST:   d.rdata = q.halt1;
                UFC_ADDR_HALT_SECOND:  d.rdata = q.halt2; // R9
                default:               d.rdata = UFC_RST_RD;
            endcase
        end

        // cts change event
        d.cts_prev = q.cts_s2;
        d.cts_evt  = (q.cts_s2 != q.cts_prev); // R11

        // receive path
        d.fifo_wr  = 1'b0;
        d.spec_evt = 1'b0;
        if (rx_char_valid) begin
            d.fifo_wr    = ~|flow_hit; // R4
            d.fifo_data  = rx_char;
            d.spec_match = match & spec_mask;
            d.spec_evt   = |(match & spec_mask); // R18
            if (|(flow_hit & UFC_MASK_HALT)) begin
                d.rx_halted = 1'b1;
            end else if (|(flow_hit & UFC_MASK_RESUME)) begin
                d.rx_halted = 1'b0;
            end
        end
        if (!sw_en) begin
            d.rx_halted = 1'b0; // R6
        end

        // transmit gating
        d.tx_allow = !q.rx_halted && !(auto_cts && q.cts_s2); // R10

        // hardware rts from fill level
        if (!auto_rts) begin
            d.rts_n = 1'b1;
        end else if (above_halt) begin
            d.rts_n = 1'b1; // R13
        end else if (below_resume) begin
            d.rts_n = 1'b0; // R13
        end

        // software halt / resume generation
        d.send_halt   = 1'b0;
        d.send_resume = 1'b0;
        if (tx_sel == UFC_SEL_NONE) begin
            d.halt_sent = 1'b0;
        end else if (!sender_busy && !q.send_halt && !q.send_resume) begin
            if (above_halt && !q.halt_sent) begin
                d.send_halt = 1'b1; // R2
                d.halt_sent = 1'b1;
            end else if (below_resume && q.halt_sent) begin
                d.send_resume = 1'b1; // R2
                d.halt_sent   = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q          <= '0;
            q.cts_s1   <= 1'b1;
            q.cts_s2   <= 1'b1;
            q.cts_prev <= 1'b1;
            q.rts_n    <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_q          = q.rdata;
    assign rx_fifo_wr_q         = q.fifo_wr;
    assign rx_fifo_data_q       = q.fifo_data;
    assign special_char_event_q = q.spec_evt;
    assign special_match_q      = q.spec_match;
    assign cts_change_flag_q    = q.cts_evt;
    assign rts_n_q              = q.rts_n;
    assign tx_data_allow_q      = q.tx_allow;

endmodule // ufc_flow_ctrl

// >>> tb/ufc_remote_model.sv
// transmitter-side partner: takes flow characters and logs them
`timescale 1ns/100ps
module ufc_remote_model (
    input  wire logic       ref_clk,
    input  wire logic       flow_req_q,
    input  wire logic [7:0] flow_char_q,
    input  wire logic [3:0] ack_delay,
    output logic            tx_flow_ack
);
    logic [7:0] got [0:7];
    int         n_got = 0;
    logic [3:0] wait_q = 4'h0;

    // ----------------------------------------
    // take a char after ack_delay cycles
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (flow_req_q && !tx_flow_ack && wait_q >= ack_delay) begin
            tx_flow_ack <= 1'b1;
            got[3'(n_got)] <= flow_char_q;
            n_got <= n_got + 1;
            wait_q <= 4'h0;
        end else begin
            tx_flow_ack <= 1'b0;
            wait_q <= flow_req_q ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule // ufc_remote_model

// >>> tb/ufc_flow_ctrl_asserts.sv
// port-level checks of the flow-control block
`timescale 1ns/100ps
module ufc_flow_ctrl_chk
    import ufc_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata_q,
    input wire logic [7:0] rx_fifo_count,
    input wire logic       rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic       rx_fifo_wr_q,
    input wire logic [7:0] rx_fifo_data_q,
    input wire logic       special_char_event_q,
    input wire logic [3:0] special_match_q,
    input wire logic       cts_n,
    input wire logic       cts_change_flag_q,
    input wire logic       flow_req_q,
    input wire logic [7:0] flow_char_q,
    input wire logic       tx_flow_ack
);
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // sequences and checked behaviours
    // ----------------------------------------
    sequence cts_edge;
        $changed(cts_n) ##1 $stable(cts_n)[*2];
    endsequence
    sequence flow_waiting;
        flow_req_q && !tx_flow_ack;
    endsequence
    sequence flow_taken;
        flow_req_q && tx_flow_ack;
    endsequence

    chk_idle_no_store: assert property (
        !rx_char_valid |=> !rx_fifo_wr_q && !special_char_event_q)
        else $error("store or event without a received char");
    chk_store_data: assert property (
        rx_fifo_wr_q |-> $past(rx_char_valid) && rx_fifo_data_q == $past(rx_char))
        else $error("stored char differs from received char");
    chk_event_match: assert property (
        special_char_event_q |-> special_match_q != 4'h0)
        else $error("special event with empty match vector");
    chk_cts_flag: assert property (
        cts_edge |-> ##[0:3] cts_change_flag_q)
        else $error("cts change not flagged");
    chk_flow_hold: assert property (
        flow_waiting |=> flow_req_q && $stable(flow_char_q))
        else $error("flow char dropped before it was taken");
    chk_flow_release: assert property (
        flow_taken |=> !flow_req_q || flow_char_q != $past(flow_char_q))
        else $error("flow char offered again after it was taken");
    chk_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata_q))
        else $error("read data moved without a read");
    chk_count_read: assert property (
        reg_rd && reg_addr == UFC_ADDR_RX_COUNT |=> reg_rdata_q == $past(rx_fifo_count))
        else $error("fill count read wrong");
endmodule // ufc_flow_ctrl_chk

bind ufc_flow_ctrl ufc_flow_ctrl_chk u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata_q(reg_rdata_q), .rx_fifo_count(rx_fifo_count),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_fifo_wr_q(rx_fifo_wr_q),
    .rx_fifo_data_q(rx_fifo_data_q), .special_char_event_q(special_char_event_q),
    .special_match_q(special_match_q), .cts_n(cts_n),
    .cts_change_flag_q(cts_change_flag_q), .flow_req_q(flow_req_q),
    .flow_char_q(flow_char_q), .tx_flow_ack(tx_flow_ack)
);

// >>> tb/ufc_flow_ctrl_tb.sv
// self-checking bench for the flow-control block
`timescale 1ns/100ps
module ufc_flow_ctrl_tb;
    import ufc_pkg::*;

    localparam logic [31:0] CHARS = 32'h93911311;
    logic       ref_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       ce = 1'b1;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       sp_en = 1'b0;
    logic [7:0] fill = 8'h00;
    logic       rx_vld = 1'b0;
    logic [7:0] rx_ch = 8'h00;
    logic       cts_n = 1'b1;
    logic [3:0] gpio = 4'h0;
    logic [3:0] ack_dly = 4'h0;
    logic [7:0] rdata, fdata, fchar;
    logic [3:0] match;
    logic       fwr, ev, cflag, rts_n, allow, freq, ack, ev_seen;
    int         mismatches = 0;
    int         n_compared = 0;
    int         cycles = 0, n_cts = 0;

    always #20 ref_clk = ~ref_clk;

    ufc_flow_ctrl u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(rdata),
        .special_detect_enable(sp_en), .rx_fifo_count(fill), .rx_char_valid(rx_vld),
        .rx_char(rx_ch), .rx_fifo_wr_q(fwr), .rx_fifo_data_q(fdata),
        .special_char_event_q(ev), .special_match_q(match), .cts_n(cts_n),
        .gpio_in(gpio), .cts_change_flag_q(cflag), .rts_n_q(rts_n),
        .tx_data_allow_q(allow), .flow_req_q(freq), .flow_char_q(fchar), .tx_flow_ack(ack)
    );

    ufc_remote_model u_remote (
        .ref_clk(ref_clk), .flow_req_q(freq), .flow_char_q(fchar),
        .ack_delay(ack_dly), .tx_flow_ack(ack)
    );

    // ----------------------------------------
    // common tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cflag === 1'b1) n_cts++;
        if (cycles == 6000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        reset_n <= 1'b0;
        sp_en <= 1'b0;
        fill <= 8'h00;
        ack_dly <= 4'h0;
        tick(8);
        reset_n <= 1'b1;
        tick(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        #1 cmp8(rdata, exp);
    endtask

    task automatic rx_chk(input logic [7:0] ch, input logic w);
        @(posedge ref_clk);
        rx_vld <= 1'b1;
        rx_ch <= ch;
        @(posedge ref_clk);
        rx_vld <= 1'b0;
        #1 cmp8({7'h0, fwr}, {7'h0, w});
        if (w) cmp8(fdata, ch);
        ev_seen = ev;
    endtask

    task automatic set_chars;
        for (int i = 0; i < 4; i++) wr(UFC_ADDR_RESUME_FIRST + 8'(i), CHARS[8*i +: 8]);
    endtask

    task automatic wait_got(input int n);
        for (int k = 0; k < 80 && u_remote.n_got < n; k++) tick(1);
        #1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [7:0] a;
        logic       w;
        gpio <= 4'h5;
        cmp8({7'h0, rts_n}, 8'h01);
        for (int i = 15; i < 25; i++) begin
            rd_chk(8'(i), 8'h00);
            wr(8'(i), {4'(i), ~4'(i)});
        end
        fill <= 8'h2a;
        for (int i = 15; i < 25; i++) begin
            a = 8'(i);
            w = (a == 8'h0f) || (a >= 8'h13 && a <= 8'h17);
            rd_chk(a, a == 8'h12 ? 8'h2a : (w ? {a[3:0], ~a[3:0]} : 8'h00));
        end
    endtask

    task automatic t_rx_flow;
        logic [3:0] m;
        do_reset();
        set_chars();
        for (int s = 0; s < 4; s++) begin
            m = {s[0], s[1], s[0], s[1]};
            wr(UFC_ADDR_FLOW_CONFIG, {2'h0, 2'(s), 4'h8});
            for (int i = 0; i < 4; i++) rx_chk(CHARS[8*i +: 8], !m[i]);
        end
        rx_chk(8'h11, 1'b0);
        tick(3);
        cmp8({7'h0, allow}, 8'h01);
        rx_chk(8'h91, 1'b0);
        tick(3);
        cmp8({7'h0, allow}, 8'h00);
        wr(UFC_ADDR_FLOW_CONFIG, 8'h30);
        rx_chk(8'h91, 1'b1);
    endtask

    task automatic t_special;
        do_reset();
        set_chars();
        sp_en <= 1'b1;
        fill <= 8'h10;
        wr(UFC_ADDR_FLOW_LEVELS, 8'h01);
        wr(UFC_ADDR_FLOW_CONFIG, 8'he0);
        rx_chk(8'h91, 1'b1);
        cmp8({ev_seen, 3'h0, match}, 8'h84);
        rx_chk(8'h13, 1'b1);
        cmp8({7'h0, ev_seen}, 8'h00);
        tick(4);
        cmp8({6'h0, freq, allow}, 8'h01);
        fill <= 8'h00;
        wr(UFC_ADDR_FLOW_CONFIG, 8'h28);
        rx_chk(8'h13, 1'b1);
        cmp8({ev_seen, 3'h0, match}, 8'h82);
        rx_chk(8'h11, 1'b0);
        gpio <= 4'h3;
        wr(UFC_ADDR_HALT_SECOND, 8'ha5);
        wr(UFC_ADDR_FLOW_CONFIG, 8'h14);
        rx_chk(8'ha3, 1'b1);
        cmp8({ev_seen, 3'h0, match}, 8'h88);
        rx_chk(8'ha5, 1'b1);
        cmp8({7'h0, ev_seen}, 8'h00);
        rd_chk(UFC_ADDR_HALT_SECOND, 8'ha5);
    endtask

    task automatic t_sender;
        int b, n;
        do_reset();
        set_chars();
        wr(UFC_ADDR_FLOW_LEVELS, 8'h24);
        for (int s = 1; s < 4; s++) begin
            n = (s == 3) ? 2 : 1;
            ack_dly <= (s == 2) ? 4'h6 : 4'h0;
            wr(UFC_ADDR_FLOW_CONFIG, {2'(s), 6'h08});
            b = u_remote.n_got;
            fill <= 8'h1f;
            tick(8);
            cmp8({7'h0, freq}, 8'h00);
            fill <= 8'h20;
            wait_got(b + n);
            cmp8(u_remote.got[3'(b)], s[1] ? 8'h91 : 8'h93);
            if (n == 2) cmp8(u_remote.got[3'(b + 1)], 8'h93);
            fill <= 8'h11;
            tick(8);
            cmp8(8'(u_remote.n_got - b), 8'(n));
            fill <= 8'h10;
            wait_got(b + 2 * n);
            cmp8(u_remote.got[3'(b + n)], s[1] ? 8'h11 : 8'h13);
            if (n == 2) cmp8(u_remote.got[3'(b + 3)], 8'h13);
        end
    endtask

    task automatic t_rts;
        logic [39:0] lv;
        lv = 40'h10_11_20_1f_00;
        do_reset();
        wr(UFC_ADDR_FLOW_LEVELS, 8'h24);
        wr(UFC_ADDR_FLOW_CONFIG, 8'h01);
        for (int i = 0; i < 5; i++) begin
            fill <= lv[8*i +: 8];
            tick(3);
            cmp8({7'h0, rts_n}, {7'h0, (i == 2 || i == 3)});
        end
        ce <= 1'b0;
        fill <= 8'h20;
        tick(3);
        cmp8({7'h0, rts_n}, 8'h00);
        ce <= 1'b1;
    endtask

    task automatic t_cts;
        do_reset();
        tick(6);
        wr(UFC_ADDR_FLOW_CONFIG, 8'h02);
        n_cts = 0;
        for (int i = 0; i < 4; i++) begin
            cts_n <= ~cts_n;
            tick(8);
            cmp8({7'h0, allow}, {7'h0, ~cts_n});
        end
        cmp8(8'(n_cts), 8'h04);
    endtask

    initial begin
        do_reset();
        t_regs();
        t_rx_flow();
        t_special();
        t_sender();
        t_rts();
        t_cts();
        wrap_up();
    end
endmodule // ufc_flow_ctrl_tb
